// ===== rtl/dct_pkg.sv
package dct_pkg;

  // ****************************************************************
  // register byte addresses on the avalon bus
  // ****************************************************************
  localparam logic [5:0] ADDR_CONTROL   = 6'h00;
  localparam logic [5:0] ADDR_MODE      = 6'h04;
  localparam logic [5:0] ADDR_CLOCK     = 6'h08;
  localparam logic [5:0] ADDR_T0_LOW    = 6'h0C;
  localparam logic [5:0] ADDR_T0_HIGH   = 6'h10;
  localparam logic [5:0] ADDR_T1_LOW    = 6'h14;
  localparam logic [5:0] ADDR_T1_HIGH   = 6'h18;
  localparam logic [5:0] ADDR_IRQ_CFG   = 6'h1C;
  localparam logic [5:0] ADDR_IRQ_EN    = 6'h20;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // timer_control_reg
  localparam int CTL_T0_RUN  = 4;
  localparam int CTL_T0_OVF  = 5;
  localparam int CTL_T1_RUN  = 6;
  localparam int CTL_T1_OVF  = 7;
  // timer_mode_reg: timer 0 in bits 3..0, timer 1 in bits 7..4
  localparam int MOD_T0_MODE = 0;
  localparam int MOD_T0_CSEL = 2;
  localparam int MOD_T0_GATE = 3;
  localparam int MOD_T1_MODE = 4;
  localparam int MOD_T1_CSEL = 6;
  localparam int MOD_T1_GATE = 7;
  // clock_control_reg
  localparam int CLK_PRESCALE = 0;
  localparam int CLK_T0_SYS   = 3;
  localparam int CLK_T1_SYS   = 4;
  // ext_irq_config_reg
  localparam int CFG_A_POL    = 3;
  localparam int CFG_B_POL    = 7;
  // irq_enable_reg
  localparam int IEN_T0       = 1;
  localparam int IEN_T1       = 3;

  // ****************************************************************
  // reset values and prescaler divides
  // ****************************************************************
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [5:0] DIV_PS_0     = 6'h0B;   // sysclk / 12
  localparam logic [5:0] DIV_PS_1     = 6'h03;   // sysclk / 4
  localparam logic [5:0] DIV_PS_2     = 6'h2F;   // sysclk / 48
  localparam logic [2:0] DIV_EXT      = 3'h7;    // external osc / 8

  // timer operating modes
  typedef enum logic [1:0] {
    DCT_M13, DCT_M16, DCT_M8R, DCT_MSPLIT
  } dct_mode_e;

endpackage : dct_pkg

// ===== rtl/dct_timers.sv
// Contract
// - two timers, four modes each, separate two-bit mode fields
// - each count is sixteen bits, accessed as low and high bytes
// - mode 0 counts thirteen bits: high byte plus low bits 4..0
// - thirteen-bit wrap to zero sets overflow flag and requests interrupt
// - counter select one counts falling edges of event pin
// - counter select zero counts sysclk or selected prescaled clock
// - counts while run set and gate off or irq input active
// - setting run never clears or reloads the count
// - external events counted up to a quarter of sysclk
// - mode 1 is mode 0 with all sixteen bits
// - mode 2 low byte counts, reloads from high byte on wrap
// - mode 3 timer 0 low byte is own eight-bit counter/timer
// - mode 3 timer 0 high byte timer, timer 1 run and flag
// - timer 0 in mode 3: timer 1 internal clocks, no flag
// - timer 0 in mode 3: timer 1 runs unless its mode is 3
// - timer 1 overflow pulse always available to other blocks
// - timer 1 uses its own bytes, bits and irq input b
// - interrupt request only with that timer's enable bit set
// - clock from five sources: sysclk, three prescales, external / 8
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
module dct_timers
  import dct_pkg::*;
(
  input  wire logic        clk,              // 125 mhz system clock
  input  wire logic        rstn,             // synchronous reset, active low
  input  wire logic [5:0]  address,          // avalon byte address
  input  wire logic        read,             // avalon read request
  input  wire logic        write,            // avalon write request
  input  wire logic [31:0] writedata,        // avalon write data
  input  wire logic [3:0]  byteenable,       // avalon byte lanes
  output logic      [31:0] readdata,         // avalon read data
  output logic             waitrequest,      // avalon stall
  input  wire logic        t0_event_pin,     // timer 0 count input
  input  wire logic        t1_event_pin,     // timer 1 count input
  input  wire logic        ext_irq_input_a,  // timer 0 gate input
  input  wire logic        ext_irq_input_b,  // timer 1 gate input
  input  wire logic        ext_osc_pin,      // external oscillator clock
  input  wire logic        t0_irq_ack,       // interrupt system clears t0 flag
  input  wire logic        t1_irq_ack,       // interrupt system clears t1 flag
  output logic             t0_irq_req,       // timer 0 interrupt request
  output logic             t1_irq_req,       // timer 1 interrupt request
  output logic             t1_overflow_tick  // timer 1 overflow, one cycle
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] timer_control_reg, next_timer_control_reg;
  logic [7:0] timer_mode_reg,    next_timer_mode_reg;
  logic [7:0] clock_control_reg, next_clock_control_reg;
  logic [7:0] ext_irq_config_reg, next_ext_irq_config_reg;
  logic [7:0] irq_enable_reg,    next_irq_enable_reg;
  logic [7:0] t0_count_low,  next_t0_count_low;
  logic [7:0] t0_count_high, next_t0_count_high;
  logic [7:0] t1_count_low,  next_t1_count_low;
  logic [7:0] t1_count_high, next_t1_count_high;
  logic [2:0] ev0_sync, next_ev0_sync;
  logic [2:0] ev1_sync, next_ev1_sync;
  logic [1:0] ga_sync,  next_ga_sync;
  logic [1:0] gb_sync,  next_gb_sync;
  logic [2:0] osc_sync, next_osc_sync;
  logic [5:0] ps_cnt,   next_ps_cnt;
  logic [2:0] ext_cnt,  next_ext_cnt;
  logic       ps_tick,  next_ps_tick;
  logic        next_waitrequest;
  logic [31:0] next_readdata;
  logic        next_t0_irq_req;
  logic        next_t1_irq_req;
  logic        next_t1_overflow_tick;

  // ****************************************************************
  // counting helpers
  // ****************************************************************
  // one increment of a timer pair in modes 0..2; returns {ovf, hi, lo}
  function automatic logic [16:0] dct_step(input logic [7:0] lo,
                                           input logic [7:0] hi,
                                           input dct_mode_e  md);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [16:0] res;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    res = {1'b0, hi, lo};
    unique case (md)
      // upper low bits just ride along, software masks them
      DCT_M13: res = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5], lo[7:5], c13[4:0]};
      DCT_M16: res = {({hi, lo} == 16'hFFFF), c16};
      DCT_M8R: res = (lo == 8'hFF) ? {1'b1, hi, hi}
                                   : {1'b0, hi, lo + 8'h01};
      DCT_MSPLIT: res = {1'b0, hi, lo};                                          // held
    endcase
    return res;
  endfunction : dct_step

  // ****************************************************************
  // combinational next state
  // ****************************************************************
  logic        bus_go;
  logic        lane0_wr;
  logic [7:0]  wd;
  logic        ev0_fall, ev1_fall, osc_rise;
  logic        int_tick0, int_tick1;
  logic        t0_en, t1_en, t0_tick, t1_tick, th0_en;
  logic        t0_split;
  dct_mode_e   m0, m1;
  logic [16:0] s0, s1;
  logic        t0_ovf, t1_ovf, t1_flag_ovf;
  logic [7:0]  rd_byte;

  always_comb begin
    // bus access completes in the cycle waitrequest is low
    bus_go   = (read || write) && !waitrequest;
    lane0_wr = write && bus_go && byteenable[0];
    wd       = writedata[7:0];

    // two-flop synchronisers, third stage only for edge compare
    next_ev0_sync = {ev0_sync[1:0], t0_event_pin};
    next_ev1_sync = {ev1_sync[1:0], t1_event_pin};
    next_ga_sync  = {ga_sync[0], ext_irq_input_a};
    next_gb_sync  = {gb_sync[0], ext_irq_input_b};
    next_osc_sync = {osc_sync[1:0], ext_osc_pin};
    // falling edge one cycle late; fine up to sysclk / 4 events
    ev0_fall = ev0_sync[2] && !ev0_sync[1];
    ev1_fall = ev1_sync[2] && !ev1_sync[1];
    osc_rise = !osc_sync[2] && osc_sync[1];

    // prescaler: three sysclk divides or external osc / 8
    next_ps_cnt  = ps_cnt;
    next_ext_cnt = ext_cnt;
    next_ps_tick = 1'b0;
    unique case (clock_control_reg[CLK_PRESCALE +: 2])
      2'd0: next_ps_tick = (ps_cnt >= DIV_PS_0);
      2'd1: next_ps_tick = (ps_cnt >= DIV_PS_1);
      2'd2: next_ps_tick = (ps_cnt >= DIV_PS_2);
      2'd3: next_ps_tick = osc_rise && (ext_cnt == DIV_EXT);
    endcase
    if (clock_control_reg[CLK_PRESCALE +: 2] == 2'd3) begin
      next_ps_cnt = 6'h00;
    end else begin
      next_ps_cnt = next_ps_tick ? 6'h00 : ps_cnt + 6'h01;
    end
    if (osc_rise) begin
      next_ext_cnt = ext_cnt + 3'h1;
    end

    // internal timebase per timer
    int_tick0 = clock_control_reg[CLK_T0_SYS] ? 1'b1 : ps_tick;
    int_tick1 = clock_control_reg[CLK_T1_SYS] ? 1'b1 : ps_tick;

    m0       = dct_mode_e'(timer_mode_reg[MOD_T0_MODE +: 2]);
    m1       = dct_mode_e'(timer_mode_reg[MOD_T1_MODE +: 2]);
    t0_split = (m0 == DCT_MSPLIT);

    // run and gate; polarity bit one means active high
    t0_en = timer_control_reg[CTL_T0_RUN] &&
            (!timer_mode_reg[MOD_T0_GATE] ||
             (ga_sync[1] == ext_irq_config_reg[CFG_A_POL]));
    t0_tick = timer_mode_reg[MOD_T0_CSEL] ? ev0_fall : int_tick0;
    th0_en  = timer_control_reg[CTL_T1_RUN] && int_tick0;

    if (t0_split) begin
      // timer 1 borrowed: internal clocks, mode field is its run
      t1_en   = (m1 != DCT_MSPLIT);
      t1_tick = int_tick1;
    end else begin
      t1_en = timer_control_reg[CTL_T1_RUN] &&
              (!timer_mode_reg[MOD_T1_GATE] ||
               (gb_sync[1] == ext_irq_config_reg[CFG_B_POL]));
      t1_tick = timer_mode_reg[MOD_T1_CSEL] ? ev1_fall : int_tick1;
    end

    // count updates; the run bit only gates, never clears
    next_t0_count_low  = t0_count_low;
    next_t0_count_high = t0_count_high;
    next_t1_count_low  = t1_count_low;
    next_t1_count_high = t1_count_high;
    t0_ovf      = 1'b0;
    t1_ovf      = 1'b0;
    t1_flag_ovf = 1'b0;

    s0 = dct_step(t0_count_low, t0_count_high, m0);
    s1 = dct_step(t1_count_low, t1_count_high, m1);
    if (t0_split) begin
      if (t0_en && t0_tick) begin
        next_t0_count_low = t0_count_low + 8'h01;
        t0_ovf = (t0_count_low == 8'hFF);
      end
      if (th0_en) begin
        next_t0_count_high = t0_count_high + 8'h01;
        t1_flag_ovf = (t0_count_high == 8'hFF);
      end
    end else if (t0_en && t0_tick) begin
      {t0_ovf, next_t0_count_high, next_t0_count_low} = s0;
    end
    if (t1_en && t1_tick && (t0_split || m1 != DCT_MSPLIT)) begin
      {t1_ovf, next_t1_count_high, next_t1_count_low} = s1;
    end
    if (!t0_split) begin
      t1_flag_ovf = t1_ovf;
    end

    // bus writes to count bytes land on this edge, over counting
    if (lane0_wr && address == ADDR_T0_LOW)  next_t0_count_low  = wd;
    if (lane0_wr && address == ADDR_T0_HIGH) next_t0_count_high = wd;
    if (lane0_wr && address == ADDR_T1_LOW)  next_t1_count_low  = wd;
    if (lane0_wr && address == ADDR_T1_HIGH) next_t1_count_high = wd;

    // configuration registers
    next_timer_mode_reg     = (lane0_wr && address == ADDR_MODE)    ? wd : timer_mode_reg;
    next_clock_control_reg  = (lane0_wr && address == ADDR_CLOCK)   ? wd : clock_control_reg;
    next_ext_irq_config_reg = (lane0_wr && address == ADDR_IRQ_CFG) ? wd : ext_irq_config_reg;
    next_irq_enable_reg     = (lane0_wr && address == ADDR_IRQ_EN)  ? wd : irq_enable_reg;

    // flags: hardware set beats a same-cycle clear or ack
    next_timer_control_reg = (lane0_wr && address == ADDR_CONTROL) ? wd : timer_control_reg;
    if (t0_irq_ack) next_timer_control_reg[CTL_T0_OVF] = 1'b0;
    if (t1_irq_ack) next_timer_control_reg[CTL_T1_OVF] = 1'b0;
    if (t0_ovf) next_timer_control_reg[CTL_T0_OVF] = 1'b1;
    if (t1_flag_ovf) next_timer_control_reg[CTL_T1_OVF] = 1'b1;

    // requests registered from flag and enable
    next_t0_irq_req = next_timer_control_reg[CTL_T0_OVF] && next_irq_enable_reg[IEN_T0];
    next_t1_irq_req = next_timer_control_reg[CTL_T1_OVF] && next_irq_enable_reg[IEN_T1];
    next_t1_overflow_tick = t1_ovf;

    // read mux; unmapped addresses read zero
    unique case (address)
      ADDR_CONTROL: rd_byte = timer_control_reg;
      ADDR_MODE:    rd_byte = timer_mode_reg;
      ADDR_CLOCK:   rd_byte = clock_control_reg;
      ADDR_T0_LOW:  rd_byte = t0_count_low;
      ADDR_T0_HIGH: rd_byte = t0_count_high;
      ADDR_T1_LOW:  rd_byte = t1_count_low;
      ADDR_T1_HIGH: rd_byte = t1_count_high;
      ADDR_IRQ_CFG: rd_byte = ext_irq_config_reg;
      ADDR_IRQ_EN:  rd_byte = irq_enable_reg;
      default:      rd_byte = RST_BYTE;
    endcase

    // one wait state per access keeps readdata a flop output
    next_waitrequest = !((read || write) && waitrequest);
    next_readdata    = (read && waitrequest) ? {24'h00_0000, rd_byte} : readdata;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // all state takes its next value every edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timer_control_reg  <= RST_BYTE;
      timer_mode_reg     <= RST_BYTE;
      clock_control_reg  <= RST_BYTE;
      ext_irq_config_reg <= RST_BYTE;
      irq_enable_reg     <= RST_BYTE;
      t0_count_low       <= RST_BYTE;
      t0_count_high      <= RST_BYTE;
      t1_count_low       <= RST_BYTE;
      t1_count_high      <= RST_BYTE;
      ev0_sync           <= 3'h0;
      ev1_sync           <= 3'h0;
      ga_sync            <= 2'h0;
      gb_sync            <= 2'h0;
      osc_sync           <= 3'h0;
      ps_cnt             <= 6'h00;
      ext_cnt            <= 3'h0;
      ps_tick            <= 1'b0;
      waitrequest        <= 1'b1;
      readdata           <= 32'h0000_0000;
      t0_irq_req         <= 1'b0;
      t1_irq_req         <= 1'b0;
      t1_overflow_tick   <= 1'b0;
    end else begin
      timer_control_reg  <= next_timer_control_reg;
      timer_mode_reg     <= next_timer_mode_reg;
      clock_control_reg  <= next_clock_control_reg;
      ext_irq_config_reg <= next_ext_irq_config_reg;
      irq_enable_reg     <= next_irq_enable_reg;
      t0_count_low       <= next_t0_count_low;
      t0_count_high      <= next_t0_count_high;
      t1_count_low       <= next_t1_count_low;
      t1_count_high      <= next_t1_count_high;
      ev0_sync           <= next_ev0_sync;
      ev1_sync           <= next_ev1_sync;
      ga_sync            <= next_ga_sync;
      gb_sync            <= next_gb_sync;
      osc_sync           <= next_osc_sync;
      ps_cnt             <= next_ps_cnt;
      ext_cnt            <= next_ext_cnt;
      ps_tick            <= next_ps_tick;
      waitrequest        <= next_waitrequest;
      readdata           <= next_readdata;
      t0_irq_req         <= next_t0_irq_req;
      t1_irq_req         <= next_t1_irq_req;
      t1_overflow_tick   <= next_t1_overflow_tick;
    end
  end

endmodule : dct_timers

// ===== testbench/dct_timers_sva.sv
`timescale 1ns/1ns
module dct_timers_sva
  import dct_pkg::*;
(
  input wire logic        clk,              // system clock
  input wire logic        rstn,             // synchronous reset, active low
  input wire logic        read,             // bus read request
  input wire logic        write,            // bus write request
  input wire logic [31:0] readdata,         // bus read data
  input wire logic        waitrequest,      // bus stall
  input wire logic        t0_irq_ack,       // timer 0 flag clear
  input wire logic        t1_irq_ack,       // timer 1 flag clear
  input wire logic        t0_irq_req,       // timer 0 request
  input wire logic        t1_irq_req,       // timer 1 request
  input wire logic        t1_overflow_tick  // timer 1 wrap pulse
);
  // ****************************************************************
  // bus handshake, request holding and reset checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking

  // exactly one wait state, then back to stalling
  bus_answer_a: assert property (
    disable iff (!rstn) (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one wait state");
  idle_stall_a: assert property (
    disable iff (!rstn) !read && !write |=> waitrequest)
    else $error("waitrequest low without a request");
  upper_zero_a: assert property (
    disable iff (!rstn) !waitrequest |-> readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  rdata_hold_a: assert property (
    disable iff (!rstn) !read |=> $stable(readdata))
    else $error("read data changed without a read");
  // flags stay until cleared; a bus write may legally clear them
  t0_hold_a: assert property (
    disable iff (!rstn) t0_irq_req && !t0_irq_ack && !write |=> t0_irq_req)
    else $error("timer 0 request dropped by itself");
  t1_hold_a: assert property (
    disable iff (!rstn) t1_irq_req && !t1_irq_ack && !write |=> t1_irq_req)
    else $error("timer 1 request dropped by itself");
  t0_ack_a: assert property (
    disable iff (!rstn) t0_irq_ack |=> !t0_irq_req)
    else $error("timer 0 ack did not clear request");
  t1_ack_a: assert property (
    disable iff (!rstn) t1_irq_ack |=> !t1_irq_req)
    else $error("timer 1 ack did not clear request");
  // no disable here: the check is about the reset itself
  reset_quiet_a: assert property (
    !rstn |=> waitrequest && !t0_irq_req && !t1_irq_req && !t1_overflow_tick)
    else $error("outputs not quiet after reset");

  cover property (disable iff (!rstn) $rose(t0_irq_req));
  cover property (disable iff (!rstn) $rose(t1_irq_req));
  cover property (disable iff (!rstn) t1_overflow_tick);
endmodule : dct_timers_sva

bind dct_timers dct_timers_sva u_sva (.clk, .rstn, .read, .write, .readdata, .waitrequest,
  .t0_irq_ack, .t1_irq_ack, .t0_irq_req, .t1_irq_req, .t1_overflow_tick);

// ===== testbench/dct_pin_model.sv
`timescale 1ns/1ns
module dct_pin_model (
  input  wire logic clk,              // system clock
  output logic      t0_event_pin,     // timer 0 count pin
  output logic      t1_event_pin,     // timer 1 count pin
  output logic      ext_irq_input_a,  // timer 0 gate input
  output logic      ext_irq_input_b,  // timer 1 gate input
  output logic      ext_osc_pin       // free running oscillator
);
  // ****************************************************************
  // external event source and gate levels
  // ****************************************************************
  // pins idle high so the first low is a real falling edge
  initial begin
    t0_event_pin = 1'b1;
    t1_event_pin = 1'b1;
    ext_irq_input_a = 1'b0;
    ext_irq_input_b = 1'b0;
    ext_osc_pin = 1'b0;
  end

  // oscillator runs free, it is a crystal not a frame clock
  always @(posedge clk) ext_osc_pin <= ~ext_osc_pin;

  // each level held two cycles, fastest legal rate is a quarter
  task pulses(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      if (sel == 0) t0_event_pin <= 1'b0; else t1_event_pin <= 1'b0;
      repeat (2) @(posedge clk);
      if (sel == 0) t0_event_pin <= 1'b1; else t1_event_pin <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask : pulses

  task set_gates(input logic a, input logic b);
    ext_irq_input_a <= a;
    ext_irq_input_b <= b;
    @(posedge clk);
  endtask : set_gates
endmodule : dct_pin_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import dct_pkg::*;
;
  logic        clk, rstn, read, write, t0_irq_ack, t1_irq_ack, waitrequest;
  logic        t0_irq_req, t1_irq_req, t1_overflow_tick, tick_seen;
  logic        t0_event_pin, t1_event_pin, ext_irq_input_a, ext_irq_input_b, ext_osc_pin;
  logic [5:0]  address;
  logic [31:0] writedata, readdata;
  logic [7:0]  rv;
  int          err_total, samples_checked;

  // ****************************************************************
  // clock, design, pins and bus tasks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  dct_timers u_dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .t0_event_pin(t0_event_pin), .t1_event_pin(t1_event_pin),
    .ext_irq_input_a(ext_irq_input_a), .ext_irq_input_b(ext_irq_input_b),
    .ext_osc_pin(ext_osc_pin), .t0_irq_ack(t0_irq_ack), .t1_irq_ack(t1_irq_ack),
    .t0_irq_req(t0_irq_req), .t1_irq_req(t1_irq_req), .t1_overflow_tick(t1_overflow_tick));

  dct_pin_model u_pins (.clk(clk), .t0_event_pin(t0_event_pin), .t1_event_pin(t1_event_pin),
    .ext_irq_input_a(ext_irq_input_a), .ext_irq_input_b(ext_irq_input_b),
    .ext_osc_pin(ext_osc_pin));

  // latch any wrap pulse, it lasts one cycle only
  always @(posedge clk) if (t1_overflow_tick === 1'b1) tick_seen <= 1'b1;

  task wrap_up;
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // request held until waitrequest is sampled low, no fixed latency assumed
  task bus(input logic rd, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h00_0000, d};
    read <= rd;
    write <= !rd;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        err_total++;
        $display("ERROR waitrequest expected 0 seen %b", waitrequest);
        wrap_up();
      end
      @(posedge clk);
    end
    rv = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask : wr

  task rc(input string nm, input logic [5:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    bus(1'b1, a, 8'h00);
    chk(nm, exp, rv & m);
  endtask : rc

  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0; read = 1'b0; write = 1'b0; address = 6'h00; writedata = 32'h0000_0000;
    t0_irq_ack = 1'b0; t1_irq_ack = 1'b0; tick_seen = 1'b0; err_total = 0; samples_checked = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rc("control reset", ADDR_CONTROL, 8'h00);
    wr(6'h24, 8'hFF);
    rc("unmapped", 6'h24, 8'h00);
    // 13-bit wrap from 0x1FFE by three pin edges; low bits 7:5 are junk
    wr(ADDR_T0_LOW, 8'hFE); wr(ADDR_T0_HIGH, 8'hFF); wr(ADDR_MODE, 8'h04);
    wr(ADDR_IRQ_EN, 8'h0A); wr(ADDR_CONTROL, 8'h10);
    u_pins.pulses(0, 3);
    wt(6);
    rc("t0 low mode0", ADDR_T0_LOW, 8'h01, 8'h1F);
    rc("t0 high mode0", ADDR_T0_HIGH, 8'h00);
    rc("t0 flag", ADDR_CONTROL, 8'h30);
    chk("t0 irq", 8'h01, {7'h00, t0_irq_req});
    t0_irq_ack <= 1'b1; wt(1); t0_irq_ack <= 1'b0; wt(1);
    chk("t0 irq ack", 8'h00, {7'h00, t0_irq_req});
    // gated 16-bit counting: edges ignored until gate input active high
    wr(ADDR_T0_LOW, 8'h00); wr(ADDR_T0_HIGH, 8'h00); wr(ADDR_MODE, 8'h0D);
    wr(ADDR_IRQ_CFG, 8'h08); wr(ADDR_CONTROL, 8'h10);
    u_pins.pulses(0, 2); wt(6);
    rc("gate closed", ADDR_T0_LOW, 8'h00);
    u_pins.set_gates(1'b1, 1'b0); wt(4);
    u_pins.pulses(0, 2); wt(6);
    rc("gate open", ADDR_T0_LOW, 8'h02);
    wr(ADDR_CONTROL, 8'h00); wr(ADDR_CONTROL, 8'h10);
    u_pins.pulses(0, 1); wt(6);
    rc("resume", ADDR_T0_LOW, 8'h03);
    // timer 1 auto-reload with its interrupt masked
    wr(ADDR_CONTROL, 8'h00); wr(ADDR_IRQ_EN, 8'h00); wr(ADDR_MODE, 8'h60);
    wr(ADDR_T1_LOW, 8'hFE); wr(ADDR_T1_HIGH, 8'h80); wr(ADDR_CONTROL, 8'h40);
    u_pins.pulses(1, 3); wt(6);
    rc("t1 low reload", ADDR_T1_LOW, 8'h81);
    rc("t1 high kept", ADDR_T1_HIGH, 8'h80);
    rc("t1 flag", ADDR_CONTROL, 8'hC0);
    chk("t1 irq masked", 8'h00, {7'h00, t1_irq_req});
    wr(ADDR_IRQ_EN, 8'h08);
    chk("t1 irq", 8'h01, {7'h00, t1_irq_req});
    t1_irq_ack <= 1'b1; wt(1); t1_irq_ack <= 1'b0; wt(1);
    chk("t1 irq ack", 8'h00, {7'h00, t1_irq_req});
    // software may set the flag by hand, then clear it again
    wr(ADDR_CONTROL, 8'hC0);
    chk("t1 irq set", 8'h01, {7'h00, t1_irq_req});
    wr(ADDR_CONTROL, 8'h40);
    chk("t1 irq clear", 8'h00, {7'h00, t1_irq_req});
    // 16-bit sysclk count from 0xFFF0 must wrap within 40 cycles
    wr(ADDR_CONTROL, 8'h00); wr(ADDR_MODE, 8'h01); wr(ADDR_CLOCK, 8'h08);
    wr(ADDR_T0_LOW, 8'hF0); wr(ADDR_T0_HIGH, 8'hFF); wr(ADDR_CONTROL, 8'h10);
    wt(40);
    rc("mode1 wrap", ADDR_CONTROL, 8'h30);
    rc("mode1 high", ADDR_T0_HIGH, 8'h00);
    // prescaled by 4: about 41 enabled cycles, phase of the divider unknown
    wr(ADDR_CONTROL, 8'h00); wr(ADDR_T0_LOW, 8'h00); wr(ADDR_T0_HIGH, 8'h00);
    wr(ADDR_CLOCK, 8'h01); wr(ADDR_CONTROL, 8'h10);
    wt(40);
    bus(1'b1, ADDR_T0_LOW, 8'h00);
    samples_checked++;
    if (rv < 8'h09 || rv > 8'h0C) begin
      err_total++;
      $display("ERROR prescale count expected 09..0c seen %h", rv);
    end
    // split mode: timer 1 runs with run bit clear and never flags
    wr(ADDR_CONTROL, 8'h00); wr(ADDR_T1_LOW, 8'hFF); wr(ADDR_T1_HIGH, 8'hFF);
    wr(ADDR_CLOCK, 8'h18); tick_seen <= 1'b0; wr(ADDR_MODE, 8'h03);
    wt(20);
    rc("no t1 flag", ADDR_CONTROL, 8'h00);
    chk("t1 tick", 8'h01, {7'h00, tick_seen});
    wrap_up();
  end
endmodule : tb_top
